/* core/bsc_pkg.sv */
// Constants, register map and state type for the boot strap capture block.
// Assumes a 32-bit APB register port and a 25-pin expansion address bus.
//
// Notes on behaviour
// - pins are inputs during reset or no lock
// - pin levels stored into config bits 24..0
// - undriven strap bits read one after reset
// - pulled-down pin stores a zero bit
// - capture on first cycle after reset release
// - software reads and overwrites strap bits
package bsc_pkg;

    localparam int STRAP_W  = 25;
    localparam int DATA_W   = 32;
    localparam int ADDR_W   = 12;

    localparam int STRAP_MSB   = 24;
    localparam int STRAP_LSB   = 0;
    localparam int MEM_MAP_BIT = 31;

    localparam logic [11:0] OFF_CONFIG   = 12'h000;
    localparam logic [11:0] OFF_STATUS   = 12'h004;
    localparam logic [11:0] OFF_CAPTURED = 12'h008;

    localparam logic [31:0] CONFIG_RESET = 32'hFFFFFFFF;
    localparam logic [24:0] STRAP_IDLE   = 25'h1FFFFFF;
    localparam logic [31:0] ZERO_WORD    = 32'h00000000;

    localparam int ST_DONE_BIT  = 0;
    localparam int ST_DRIVE_BIT = 1;
    localparam int ST_LOCK_BIT  = 2;
    localparam int ST_LOST_BIT  = 3;

    typedef enum logic [1:0] {
        BSC_HOLD,
        BSC_RUN,
        BSC_UNLOCKED
    } bsc_state_t;

endpackage

/* core/bsc_sync3.sv */
// Three-stage synchroniser with agreement filter for asynchronous pin levels.
// Assumes inputs are quasi-static; output follows once stages two and three agree.
`timescale 1ns/1ps
module bsc_sync3 #(
    parameter int W = 1
) (
    // clock
    input  wire logic         clk,
    // asynchronous level in, filtered level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // no reset: the chain must keep tracking the pins while reset is held
    always_ff @(posedge clk) begin
        s1 <= d;
        s2 <= s1;
        s3 <= s2;
        // a level counts only once two stages agree, so one metastable sample is filtered
        if (s2 == s3) begin
            q <= s2;
        end
    end

endmodule

/* core/bsc_apb_port.sv */
// APB slave handshake (one wait state, registered answer) and the strap capture top level.
// Assumes pins and lock come from outside the clock domain; reset is synchronous to the clock.
`timescale 1ns/1ps
module bsc_apb_port (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // bus request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    // decode from the block
    input  wire logic        hit,
    input  wire logic [31:0] rdata,
    // bus answer
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // write commit pulse
    output logic             wr_fire
);

    logic access;

    assign access  = psel & penable & ~pready;
    assign wr_fire = psel & penable & pready & pwrite & ~pslverr;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= bsc_pkg::ZERO_WORD;
            pslverr <= 1'b0;
        end else begin
            pready  <= access;
            pslverr <= access & ~hit;
            if (access) begin
                prdata <= (!pwrite && hit) ? rdata : bsc_pkg::ZERO_WORD;
            end
        end
    end

endmodule

module bsc_strap_capture (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // clock synthesizer lock, asynchronous
    input  wire logic        CLOCK_SYNTH_LOCK_FLAG,
    // register bus
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // expansion address pins
    input  wire logic [24:0] BUS_ADDR,
    input  wire logic [24:0] EXPANSION_ADDRESS_PINS_IN,
    output logic      [24:0] EXPANSION_ADDRESS_PINS_OUT,
    output logic             EXPANSION_ADDRESS_PINS_OE_N
);

    bsc_pkg::bsc_state_t state;
    bsc_pkg::bsc_state_t next_state;
    logic [24:0]         strap_q;
    logic                lock_q;
    logic [31:0]         config_reg;
    logic [24:0]         captured;
    logic                done;
    logic                next_oe_n;
    logic                capture;
    logic                sel_config;
    logic                sel_status;
    logic                sel_captured;
    logic                unlocked;
    logic                hit;
    logic                wr_fire;
    logic                wr_cfg;
    logic [31:0]         status_word;
    logic [31:0]         rdata;

    bsc_sync3 #(.W(25)) u_strap_sync (
        .clk (CLK),
        .d   (EXPANSION_ADDRESS_PINS_IN),
        .q   (strap_q)
    );

    bsc_sync3 #(.W(1)) u_lock_sync (
        .clk (CLK),
        .d   (CLOCK_SYNTH_LOCK_FLAG),
        .q   (lock_q)
    );

    bsc_apb_port u_apb (
        .clk     (CLK),
        .rst_n   (RST_N),
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .hit     (hit),
        .rdata   (rdata),
        .pready  (PREADY),
        .prdata  (PRDATA),
        .pslverr (PSLVERR),
        .wr_fire (wr_fire)
    );

    assign sel_config   = (PADDR == bsc_pkg::OFF_CONFIG);
    assign sel_status   = (PADDR == bsc_pkg::OFF_STATUS);
    assign sel_captured = (PADDR == bsc_pkg::OFF_CAPTURED);
    // status and the capture snapshot are read-only views: a write to them is refused
    assign hit          = sel_config | (~PWRITE & (sel_status | sel_captured));
    assign wr_cfg       = wr_fire & sel_config;
    // one cycle only: the state leaves hold at the first edge with reset released
    assign capture      = (state == bsc_pkg::BSC_HOLD) & RST_N;
    assign unlocked     = (state == bsc_pkg::BSC_UNLOCKED);
    assign status_word  = {28'h0000000, unlocked, lock_q, ~EXPANSION_ADDRESS_PINS_OE_N, done};
    assign rdata        = sel_config   ? config_reg :
                          sel_status   ? status_word :
                          sel_captured ? {7'h00, captured} : bsc_pkg::ZERO_WORD;
    // pins are driven only while running with lock
    assign next_oe_n    = (next_state != bsc_pkg::BSC_RUN);

    always_comb begin
        next_state = state;
        case (state)
            bsc_pkg::BSC_HOLD: begin
                next_state = lock_q ? bsc_pkg::BSC_RUN : bsc_pkg::BSC_UNLOCKED;
            end
            bsc_pkg::BSC_RUN: begin
                if (!lock_q) begin
                    next_state = bsc_pkg::BSC_UNLOCKED;
                end
            end
            bsc_pkg::BSC_UNLOCKED: begin
                if (lock_q) begin
                    next_state = bsc_pkg::BSC_RUN;
                end
            end
            default: begin
                next_state = bsc_pkg::BSC_HOLD;
            end
        endcase
        if (!RST_N) begin
            next_state = bsc_pkg::BSC_HOLD;
        end
    end

    always_ff @(posedge CLK) begin
        state                       <= next_state;
        EXPANSION_ADDRESS_PINS_OE_N <= next_oe_n;
        EXPANSION_ADDRESS_PINS_OUT  <= BUS_ADDR;
    end

    // a reset shorter than the synchroniser depth would capture stale pin levels
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            config_reg <= bsc_pkg::CONFIG_RESET;
            captured   <= bsc_pkg::STRAP_IDLE;
            done       <= 1'b0;
        end else if (capture) begin
            config_reg[bsc_pkg::STRAP_MSB:bsc_pkg::STRAP_LSB] <= strap_q;
            captured   <= strap_q;
            done       <= 1'b1;
        end else if (wr_cfg) begin
            config_reg <= PWDATA;
        end
    end

    pins_released_a: assert property (@(posedge CLK) !RST_N |=> EXPANSION_ADDRESS_PINS_OE_N)
        else $error("address pins driven during reset");

    unlock_release_a:
        assert property (@(posedge CLK) disable iff (!RST_N) !lock_q |=> EXPANSION_ADDRESS_PINS_OE_N)
        else $error("address pins driven without lock");

    strap_store_a:
        assert property (@(posedge CLK) capture |=> config_reg[24:0] == $past(strap_q))
        else $error("strap levels not stored");

    ones_default_a: assert property (@(posedge CLK) !RST_N |=> config_reg == bsc_pkg::CONFIG_RESET)
        else $error("configuration not all ones after reset");

    capture_first_a: assert property (@(posedge CLK) !RST_N ##1 RST_N |-> capture)
        else $error("no capture on first cycle after reset");

    write_lands_a:
        assert property (@(posedge CLK) disable iff (!RST_N) wr_cfg |=> config_reg == $past(PWDATA))
        else $error("configuration write lost");

    bits_kept_a:
        assert property (@(posedge CLK) disable iff (!RST_N) !capture && !wr_cfg |=> $stable(config_reg))
        else $error("configuration changed without a write");

    drive_run_a:
        assert property (@(posedge CLK) state == bsc_pkg::BSC_RUN |-> !EXPANSION_ADDRESS_PINS_OE_N)
        else $error("address pins not driven while running");

endmodule

/* testbench/bsc_board.sv */
// Board straps on the expansion address pins.
// Assumes the pins are released while oe_n is high.
`timescale 1ns/1ps
module bsc_board (
    // enable, device level, straps
    input  wire logic        oe_n,
    input  wire logic [24:0] drv,
    input  wire logic [24:0] pd,
    // pin level
    output logic      [24:0] pin
);
    // a released pin reads high unless strapped low
    assign pin = oe_n ? ~pd : drv;
endmodule

/* testbench/reset_strap_capture_bench.sv */
// Bench for the strap capture block: captures, APB access, lock loss, mid-run reset.
// Assumes an answer within 50 cycles of the access phase.
`timescale 1ns/1ps
module reset_strap_capture_bench;
    logic        clk = 0, rst_n = 0, lock = 1, sel = 0, en = 0, wr = 0, e;
    logic [11:0] addr = 12'h000;
    logic [24:0] pd = 25'h15A5A5, bus = 25'h0ABCDE, pin, pout;
    logic [31:0] wdata = 32'h00000000, rd, prd;
    logic        rdy, err, oe_n;
    int          num_errors = 0, n_tests = 0;
`define CHK(n, x, s) begin n_tests++; if ((s) !== (x)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", n, x, s); end end
    initial forever #2 clk = ~clk;
    bsc_board B (.oe_n(oe_n), .drv(pout), .pd(pd), .pin(pin));
    bsc_strap_capture DUT (.CLK(clk), .RST_N(rst_n), .CLOCK_SYNTH_LOCK_FLAG(lock),
        .PSEL(sel), .PENABLE(en), .PWRITE(wr), .PADDR(addr), .PWDATA(wdata),
        .PRDATA(prd), .PREADY(rdy), .PSLVERR(err), .BUS_ADDR(bus),
        .EXPANSION_ADDRESS_PINS_IN(pin), .EXPANSION_ADDRESS_PINS_OUT(pout),
        .EXPANSION_ADDRESS_PINS_OE_N(oe_n));
    task complete_run;
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hold the request until pready is seen high
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        sel <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        en <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 50);
        if (k >= 50) num_errors++;
        rd = prd;
        e = err;
        en <= 1'b0;
        sel <= 1'b0;
    endtask
    initial begin
        #20000 num_errors++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge clk);
        `CHK("oe in reset", 1'b1, oe_n)
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("oe run", 1'b0, oe_n)
        `CHK("drive", bus, pout)
        xfer(0, bsc_pkg::OFF_CONFIG, 32'h00000000);
        `CHK("strap", {7'h7F, ~pd}, rd)
        xfer(0, bsc_pkg::OFF_CAPTURED, 32'h00000000);
        `CHK("captured", {7'h00, ~pd}, rd)
        xfer(0, bsc_pkg::OFF_STATUS, 32'h00000000);
        `CHK("status", 32'h00000007, rd)
        pd <= 25'h0000000;
        xfer(1, bsc_pkg::OFF_CONFIG, 32'h7E0A5A5A);
        xfer(0, bsc_pkg::OFF_CONFIG, 32'h00000000);
        `CHK("bit31 cleared", 32'h7E0A5A5A, rd)
        xfer(1, bsc_pkg::OFF_CONFIG, 32'h12345678);
        xfer(0, bsc_pkg::OFF_CONFIG, 32'h00000000);
        `CHK("overwrite", 32'h12345678, rd)
        xfer(1, bsc_pkg::OFF_STATUS, 32'h00000000);
        `CHK("ro write", 1'b1, e)
        xfer(0, 12'h010, 32'h00000000);
        `CHK("unmapped", 1'b1, e)
        lock <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("oe unlocked", 1'b1, oe_n)
        xfer(0, bsc_pkg::OFF_STATUS, 32'h00000000);
        `CHK("status unlocked", 32'h00000009, rd)
        xfer(0, bsc_pkg::OFF_CONFIG, 32'h00000000);
        `CHK("kept", 32'h12345678, rd)
        lock <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("oe relocked", 1'b0, oe_n)
        rst_n <= 1'b0;
        pd <= 25'h0000011;
        repeat (10) @(posedge clk);
        `CHK("oe mid reset", 1'b1, oe_n)
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(0, bsc_pkg::OFF_CONFIG, 32'h00000000);
        `CHK("recapture", 32'hFFFFFFEE, rd)
        complete_run;
    end
endmodule
